// ==== hdl/output_compare_timebase.v ====
// One output compare channel with its own 16-bit time base.
// Assumes sync events and timer ticks are one-cycle pulses on this clock;
// the external clock pin is asynchronous and gets synchronised here.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "output_compare_timebase_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - Free-running counter counts up, wrapping FFFF to 0000.
// - Event when counter equals primary (single, toggle modes) or secondary (double modes, PWM period end) match value.
// - Synchronous mode runs as soon as clock source is enabled.
// - Selected sync event resets counter to zero in synchronous mode.
// - Trigger mode holds counter stopped until selected event arrives.
// - Sync source select zero, and reset default, mean free-running.
// - Nonzero sync source select picks one of 31 sources.
// - Control two bit 7 set gives trigger mode, clear synchronous.
// - Odd channel lower half, even channel upper half of 32 bits.
// - Lower half wrap increments the upper half counter when cascaded.
// - Six selectable clock sources drive the channel counter.
// - Single pulse, continuous pulse and continuous PWM modes.
// - Independent primary and secondary match registers.
// - In double modes, output leaves default on primary, returns on secondary match.
// - Event flag on primary in single, secondary in double modes.
// - PWM match values latch only when the period completes.
module output_compare_timebase #(
    parameter UPPER_HALF = 0
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // Clock sources
    input wire [3:0] timer_ticks,
    input wire clock_pin,
    // Sync and trigger sources, bit n-1 for code n of 1 to 30
    input wire [30:0] sync_events,
    // Cascade link
    input wire lower_wrap_in,
    output reg wrap_out,
    // Compare output and events
    output reg compare_out,
    output reg compare_event,
    output wire irq
);

////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta_q;
reg rst_sync_q;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        rst_meta_q <= 1'b0;
        rst_sync_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_sync_q <= rst_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// Registers

reg [2:0] mode_q;
reg [2:0] clksel_q;
reg [4:0] sync_sel_q;
reg trig_status_q;
reg trigger_mode_select_q;
reg cascade_enable_q;
reg [15:0] primary_match_value_q;
reg [15:0] secondary_match_value_q;
reg [15:0] primary_live_q;
reg [15:0] secondary_live_q;
reg [15:0] compare_counter_q;
reg [2:0] status_q;
reg [2:0] mask_q;
reg shot_done_q;

wire pin_rise;

pin_tick_sync u_pin_sync (
    .clock(clock),
    .rst_n(rst_sync_q),
    .pin(clock_pin),
    .rise(pin_rise)
);

function is_pwm;
    input [2:0] m;
    begin
        is_pwm = (m == `MODE_PWM_EDGE) || (m == `MODE_PWM_CENTER);
    end
endfunction

function is_double;
    input [2:0] m;
    begin
        is_double = (m == `MODE_DOUBLE_ONCE) || (m == `MODE_DOUBLE_CONT) ||
            is_pwm(m);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Time base

reg tick;
reg sync_hit;
wire sync_mode;
wire trig_mode;
wire running;
wire advance;
wire [15:0] count_inc;
reg [15:0] count_d;
wire prim_hit;
wire sec_hit;
wire period_end;
wire trig_set;

// Clock source select
always @* begin
    case (clksel_q)
        `CLK_TICK0: tick = timer_ticks[0];
        `CLK_TICK1: tick = timer_ticks[1];
        `CLK_TICK2: tick = timer_ticks[2];
        `CLK_TICK3: tick = timer_ticks[3];
        `CLK_PIN: tick = pin_rise;
        `CLK_SYSTEM: tick = 1'b1;
        default: tick = 1'b0;
    endcase
end

// Source code n maps to event bit n-1; self sync is the period end
always @* begin
    if (sync_sel_q == `SYNC_NONE) begin
        sync_hit = 1'b0;
    end else if (sync_sel_q == `SYNC_SELF) begin
        sync_hit = 1'b0;
    end else begin
        sync_hit = sync_events[sync_sel_q - 5'h01];
    end
end

assign sync_mode = (sync_sel_q != `SYNC_NONE) &&
    !trigger_mode_select_q;
assign trig_mode = (sync_sel_q != `SYNC_NONE) && trigger_mode_select_q;

// Counting starts with an enabled source; trigger mode also needs status
assign running = (mode_q != `MODE_OFF) &&
    (!trig_mode || trig_status_q);

// Upper half of a pair counts lower half wraps instead of ticks
assign advance = running && ((cascade_enable_q && (UPPER_HALF != 0)) ?
    lower_wrap_in : tick);
assign count_inc = compare_counter_q + 16'h0001;

assign trig_set = trig_mode && sync_hit && !trig_status_q;

// Matches judged on the value just reached
assign prim_hit = advance && (count_d == primary_live_q);
assign sec_hit = advance && (count_d == secondary_live_q);
assign period_end = is_pwm(mode_q) && advance &&
    (compare_counter_q == secondary_live_q);

always @* begin
    count_d = compare_counter_q;
    if (trig_mode && !trig_status_q) begin
        count_d = `COUNTER_RESET;
    end else if (sync_mode && sync_hit) begin
        count_d = `COUNTER_RESET;
    end else if (advance) begin
        if (period_end || (sync_mode && sync_sel_q == `SYNC_SELF &&
                compare_counter_q == secondary_live_q)) begin
            count_d = `COUNTER_RESET;
        end else begin
            count_d = count_inc;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Register writes and time base state

wire wrap_now;
wire rd_status;

assign wrap_now = advance && (compare_counter_q == `COUNTER_MAX) &&
    !period_end;
assign rd_status = rd && (addr == `ADDR_STATUS);

always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
        mode_q <= `MODE_OFF;
        clksel_q <= 3'h0;
        sync_sel_q <= `SYNC_NONE;
        trig_status_q <= 1'b0;
        trigger_mode_select_q <= 1'b0;
        cascade_enable_q <= 1'b0;
        primary_match_value_q <= 16'h0000;
        secondary_match_value_q <= 16'h0000;
        primary_live_q <= 16'h0000;
        secondary_live_q <= 16'h0000;
        compare_counter_q <= `COUNTER_RESET;
        mask_q <= 3'h0;
    end else begin
        compare_counter_q <= count_d;
        if (trig_set) begin
            trig_status_q <= 1'b1;
        end
        if (!trig_mode) begin
            trig_status_q <= 1'b0;
        end
        // Buffered values reach the comparators at period end in PWM
        if (!is_pwm(mode_q) || period_end) begin
            primary_live_q <= primary_match_value_q;
            secondary_live_q <= secondary_match_value_q;
        end
        if (wr) begin
            case (addr)
                `ADDR_CONTROL_ONE: begin
                    mode_q <= wdata[`MODE_MSB:`MODE_LSB];
                    clksel_q <= wdata[`CLKSEL_MSB:`CLKSEL_LSB];
                end
                `ADDR_CONTROL_TWO: begin
                    sync_sel_q <= wdata[`SYNC_MSB:`SYNC_LSB];
                    trigger_mode_select_q <= wdata[`TRIG_MODE_BIT];
                    cascade_enable_q <= wdata[`CASCADE_BIT];
                    // Hardware set wins over a software clear
                    trig_status_q <= wdata[`TRIG_STATUS_BIT] | trig_set;
                end
                `ADDR_PRIMARY: primary_match_value_q <= wdata;
                `ADDR_SECONDARY: secondary_match_value_q <= wdata;
                `ADDR_COUNTER: compare_counter_q <= wdata;
                `ADDR_MASK: mask_q <= wdata[2:0];
                default: mask_q <= mask_q;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Output waveform and events

reg out_d;
reg done_d;
reg event_d;

always @* begin
    out_d = compare_out;
    done_d = shot_done_q;
    event_d = 1'b0;
    case (mode_q)
        `MODE_SINGLE_HIGH: begin
            if (prim_hit && !shot_done_q) begin
                out_d = 1'b1;
                done_d = 1'b1;
                event_d = 1'b1;
            end
        end
        `MODE_SINGLE_LOW: begin
            if (prim_hit && !shot_done_q) begin
                out_d = 1'b0;
                done_d = 1'b1;
                event_d = 1'b1;
            end
        end
        `MODE_TOGGLE: begin
            if (prim_hit) begin
                out_d = ~compare_out;
                event_d = 1'b1;
            end
        end
        `MODE_DOUBLE_ONCE, `MODE_DOUBLE_CONT: begin
            if (prim_hit && !shot_done_q) begin
                out_d = 1'b1;
            end
            if (sec_hit && !shot_done_q) begin
                out_d = 1'b0;
                event_d = 1'b1;
                done_d = (mode_q == `MODE_DOUBLE_ONCE);
            end
        end
        `MODE_PWM_EDGE, `MODE_PWM_CENTER: begin
            // High from period start, low at the duty match
            if (period_end) begin
                out_d = (primary_match_value_q != 16'h0000);
                event_d = 1'b1;
            end else if (prim_hit) begin
                out_d = 1'b0;
            end
        end
        default: begin
            out_d = 1'b0;
            done_d = 1'b0;
        end
    endcase
    // Rewriting control one rearms a single shot
    if (wr && addr == `ADDR_CONTROL_ONE) begin
        done_d = 1'b0;
        out_d = (wdata[`MODE_MSB:`MODE_LSB] == `MODE_SINGLE_LOW);
    end
end

always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
        compare_out <= 1'b0;
        shot_done_q <= 1'b0;
        compare_event <= 1'b0;
        wrap_out <= 1'b0;
        status_q <= 3'h0;
    end else begin
        compare_out <= out_d;
        shot_done_q <= done_d;
        compare_event <= event_d;
        wrap_out <= wrap_now;
        // Read clears, but a new event in the same cycle stays set
        status_q <= (rd_status ? 3'h0 : status_q) |
            {trig_set, wrap_now, event_d};
    end
end

assign irq = |(status_q & mask_q);

////////////////////////////////////////////////////////////////////////////
// Read data, one cycle after the strobe

always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
        rdata <= 16'h0000;
    end else if (rd) begin
        case (addr)
            `ADDR_CONTROL_ONE:
                rdata <= {3'h0, clksel_q, 7'h00, mode_q};
            `ADDR_CONTROL_TWO:
                rdata <= {7'h00, cascade_enable_q, trigger_mode_select_q,
                    trig_status_q, 1'b0, sync_sel_q};
            `ADDR_PRIMARY: rdata <= primary_match_value_q;
            `ADDR_SECONDARY: rdata <= secondary_match_value_q;
            `ADDR_COUNTER: rdata <= compare_counter_q;
            `ADDR_STATUS: rdata <= {13'h0000, status_q};
            `ADDR_MASK: rdata <= {13'h0000, mask_q};
            default: rdata <= 16'h0000;
        endcase
    end else begin
        rdata <= 16'h0000;
    end
end

endmodule // output_compare_timebase

// ==== hdl/output_compare_timebase_consts.vh ====
// Constants of the output compare time base: offsets, fields, resets.
// Assumes inclusion by bare name from the design files only.
`ifndef OUTPUT_COMPARE_TIMEBASE_CONSTS_VH
`define OUTPUT_COMPARE_TIMEBASE_CONSTS_VH

// Register indices on the plain register port
`define ADDR_CONTROL_ONE 4'h0
`define ADDR_CONTROL_TWO 4'h1
`define ADDR_PRIMARY 4'h2
`define ADDR_SECONDARY 4'h3
`define ADDR_COUNTER 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_MASK 4'h6

// Control one fields
`define MODE_LSB 0
`define MODE_MSB 2
`define CLKSEL_LSB 10
`define CLKSEL_MSB 12

// Control two fields
`define SYNC_LSB 0
`define SYNC_MSB 4
`define TRIG_STATUS_BIT 6
`define TRIG_MODE_BIT 7
`define CASCADE_BIT 8

// Operating modes
`define MODE_OFF 3'h0
`define MODE_SINGLE_HIGH 3'h1
`define MODE_SINGLE_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_DOUBLE_ONCE 3'h4
`define MODE_DOUBLE_CONT 3'h5
`define MODE_PWM_EDGE 3'h6
`define MODE_PWM_CENTER 3'h7

// Clock source codes
`define CLK_TICK0 3'h0
`define CLK_TICK1 3'h1
`define CLK_TICK2 3'h2
`define CLK_TICK3 3'h3
`define CLK_PIN 3'h4
`define CLK_SYSTEM 3'h7

// Sync source codes
`define SYNC_NONE 5'h00
`define SYNC_SELF 5'h1F

// Status bits
`define ST_EVENT 0
`define ST_WRAP 1
`define ST_TRIG 2

// Reset values and counter maximum
`define COUNTER_RESET 16'h0000
`define CONTROL_RESET 16'h0000
`define COUNTER_MAX 16'hFFFF

`endif

// ==== hdl/pin_tick_sync.v ====
// Two-flop synchroniser with rising edge pulse for an external clock pin.
// Assumes the pin is slower than half the system clock.
`timescale 1ns/1ns

module pin_tick_sync (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Pin and pulse
    input wire pin,
    output wire rise
);

reg meta_q;
reg sync_q;
reg last_q;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        last_q <= 1'b0;
    end else begin
        meta_q <= pin;
        sync_q <= meta_q;
        last_q <= sync_q;
    end
end

// Edge taken only past the second flop
assign rise = sync_q & ~last_q;

endmodule // pin_tick_sync

// ==== tb/oc_port_checker_assertions.sv ====
// Port checker for one output compare channel.
// Assumes it is bound to the channel top and sees only its ports.
`timescale 1ns/1ns
module oc_port_checker (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    // Channel outputs
    input wire wrap_out,
    input wire compare_out,
    input wire compare_event,
    input wire irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
    unmapped_read_zero_a: assert property (
        rd && addr > 4'h6 |=> rdata == 16'h0000) else $error("unmapped read");
    rdata_idle_zero_a: assert property (
        !rd |=> rdata == 16'h0000) else $error("read data not idle");
    wrap_one_pulse_a: assert property (
        wrap_out |=> !wrap_out) else $error("wrap pulse too long");
    reset_quiet_a: assert property (
        $rose(rst_n) |-> ({compare_out, compare_event, wrap_out, irq} == 4'h0)
        [*2]) else $error("outputs busy after reset");
    primary_readback_a: assert property (
        wr && addr == 4'h2 ##1 rd && addr == 4'h2 |=>
        rdata == $past(wdata, 2)) else $error("primary readback");
    secondary_readback_a: assert property (
        wr && addr == 4'h3 ##1 rd && addr == 4'h3 |=>
        rdata == $past(wdata, 2)) else $error("secondary readback");
    ctrl_one_readback_a: assert property (
        wr && addr == 4'h0 ##1 rd && addr == 4'h0 |=>
        rdata == ($past(wdata, 2) & 16'h1C07))
        else $error("ctrl one readback");
    ctrl_two_readback_a: assert property (
        wr && addr == 4'h1 ##1 rd && addr == 4'h1 |=> (rdata & 16'hFFBF) ==
        ($past(wdata, 2) & 16'h019F)) else $error("ctrl two readback");
    event_seen_c: cover property (compare_event);
    wrap_seen_c: cover property (wrap_out);
    irq_seen_c: cover property (irq);
endmodule // oc_port_checker

// ==== tb/oc_event_source.sv ====
// Far-side model: timer ticks, clock pin, sync pulses, lower half wraps.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ns
module oc_event_source (
    // Clock
    input wire clock,
    // Requests from the bench
    input wire fire,
    input wire [4:0] fire_code,
    input wire wrap_req,
    // Event outputs
    output reg [3:0] timer_ticks = 4'h0,
    output reg clock_pin = 1'b0,
    output reg [30:0] sync_events = 31'h0,
    output reg lower_wrap = 1'b0
);
    reg [3:0] div_q = 4'h0;
    // Pulses last one cycle, as on-chip sources do
    always @(posedge clock) begin
        div_q <= div_q + 4'h1;
        timer_ticks <= {&div_q, &div_q[2:0], &div_q[1:0], div_q[0]};
        clock_pin <= div_q[3];
        sync_events <= fire ? 31'h1 << (fire_code - 5'h1) : 31'h0;
        lower_wrap <= wrap_req;
    end
endmodule // oc_event_source

// ==== tb/output_compare_timebase_tb.sv ====
// Bench for one output compare channel, wired as the upper half.
// Assumes the far-side model supplies all event inputs.
`timescale 1ns/1ns
module output_compare_timebase_tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg fire = 1'b0;
    reg [4:0] fire_code = 5'h00;
    reg wrap_req = 1'b0;
    reg [15:0] got;
    wire [15:0] rdata;
    wire [3:0] timer_ticks;
    wire [30:0] sync_events;
    wire clock_pin, lower_wrap, wrap_out, compare_out, compare_event, irq;
    wire [2:0] outs = {wrap_out, compare_out, compare_event};
    integer err_total = 0;
    integer tests_run = 0;
    integer n;
    always #5 clock = ~clock;
////////////////////////////////////////////////////////////////////////////
    output_compare_timebase #(.UPPER_HALF(1)) output_compare_timebase_inst (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .timer_ticks(timer_ticks),
        .clock_pin(clock_pin), .sync_events(sync_events),
        .lower_wrap_in(lower_wrap), .wrap_out(wrap_out),
        .compare_out(compare_out), .compare_event(compare_event), .irq(irq));
    oc_event_source oc_event_source_inst (
        .clock(clock), .fire(fire), .fire_code(fire_code),
        .wrap_req(wrap_req), .timer_ticks(timer_ticks),
        .clock_pin(clock_pin), .sync_events(sync_events),
        .lower_wrap(lower_wrap));
////////////////////////////////////////////////////////////////////////////
    task chk(input [15:0] seen, input [15:0] exp, input string what);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    // A write just lowered its strobe in this step: let one edge pass
    task wreg(input [3:0] a, input [15:0] d);
        if (wr === 1'b1)
            @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rget(input [3:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
        got = rdata;
    endtask
    task rchk(input [3:0] a, input [15:0] exp, input string what);
        rget(a);
        chk(got, exp, what);
    endtask
    // Gap cycle keeps a request line from being set twice in one step
    task pulse(input [4:0] code, input w);
        fire_code <= code;
        fire <= !w;
        wrap_req <= w;
        @(posedge clock);
        fire <= 1'b0;
        wrap_req <= 1'b0;
        @(posedge clock);
    endtask
    task wait_for(input integer which);
        n = 0;
        do begin
            @(posedge clock);
            n = n + 1;
        end while (outs[which] !== 1'b1 && n < 200);
        chk({15'h0, n < 200}, 16'h0001, "output wait");
    endtask
    // High time of the output after a period start, in clock cycles
    task duty(input [15:0] exp, input string what);
        n = 0;
        do begin
            @(posedge clock);
            n = n + 1;
        end while (compare_out === 1'b1 && n < 200);
        chk(n[15:0], exp, what);
    endtask
    task results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total = err_total + 1;
        results;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rchk(4'h0, 16'h0000, "ctrl one");
        rchk(4'h1, 16'h0000, "ctrl two");
        rchk(4'h4, 16'h0000, "counter");
        wreg(4'h9, 16'hFFFF);
        rchk(4'h9, 16'h0000, "unmapped");
        wreg(4'h2, 16'hA5C3);
        rchk(4'h2, 16'hA5C3, "primary");
        wreg(4'h3, 16'h5A3C);
        rchk(4'h3, 16'h5A3C, "secondary");
        wreg(4'h1, 16'hFFFF);
        rchk(4'h1, 16'h01DF, "ctrl two");
        wreg(4'h1, 16'h0000);
        rchk(4'h1, 16'h0000, "ctrl two");
        wreg(4'h0, 16'hFFFF);
        rchk(4'h0, 16'h1C07, "ctrl one");
        // Single shot high, interrupt unmasked
        wreg(4'h0, 16'h0000);
        wreg(4'h6, 16'h0001);
        wreg(4'h4, 16'h0000);
        wreg(4'h2, 16'h0003);
        wreg(4'h0, 16'h1C01);
        wait_for(0);
        chk({15'h0, compare_out}, 16'h0001, "pulse out");
        chk({15'h0, irq}, 16'h0001, "irq");
        rchk(4'h5, 16'h0001, "status");
        chk({15'h0, irq}, 16'h0000, "irq cleared");
        // Double compare, interrupt masked
        wreg(4'h0, 16'h0000);
        wreg(4'h6, 16'h0000);
        wreg(4'h4, 16'h0000);
        wreg(4'h2, 16'h0002);
        wreg(4'h3, 16'h0005);
        wreg(4'h0, 16'h1C04);
        wait_for(1);
        chk({15'h0, compare_event}, 16'h0000, "no primary flag");
        wait_for(0);
        chk({15'h0, compare_out}, 16'h0000, "back to default");
        chk({15'h0, irq}, 16'h0000, "masked irq");
        rchk(4'h5, 16'h0001, "status");
        // Synchronous mode: runs at once, sync pulse clears
        wreg(4'h0, 16'h0000);
        wreg(4'h2, 16'hFFF0);
        wreg(4'h4, 16'h0000);
        wreg(4'h1, 16'h0001);
        wreg(4'h0, 16'h1C03);
        repeat (30) @(posedge clock);
        rget(4'h4);
        chk({15'h0, got > 16'h0010}, 16'h0001, "sync run");
        pulse(5'h01, 1'b0);
        @(posedge clock);
        rget(4'h4);
        chk({15'h0, got < 16'h0008}, 16'h0001, "sync clear");
        // Trigger mode: held until its source fires
        wreg(4'h0, 16'h0000);
        wreg(4'h4, 16'h0000);
        wreg(4'h1, 16'h0082);
        wreg(4'h0, 16'h1C03);
        repeat (10) @(posedge clock);
        rchk(4'h4, 16'h0000, "held");
        rchk(4'h1, 16'h0082, "untriggered");
        pulse(5'h02, 1'b0);
        repeat (3) @(posedge clock);
        rchk(4'h1, 16'h00C2, "triggered");
        rchk(4'h5, 16'h0004, "status");
        rget(4'h4);
        chk({15'h0, got != 16'h0000}, 16'h0001, "running");
        // Free run across the top
        wreg(4'h0, 16'h0000);
        wreg(4'h1, 16'h0000);
        wreg(4'h4, 16'hFFFC);
        wreg(4'h0, 16'h1C03);
        wait_for(2);
        rget(4'h4);
        chk({15'h0, got < 16'h0008}, 16'h0001, "wrapped");
        rchk(4'h5, 16'h0002, "status");
        // Cascade: count lower half wraps only when enabled
        wreg(4'h0, 16'h0000);
        wreg(4'h4, 16'h0000);
        wreg(4'h1, 16'h0100);
        wreg(4'h0, 16'h1403);
        repeat (3) pulse(5'h00, 1'b1);
        rchk(4'h4, 16'h0003, "upper half");
        wreg(4'h1, 16'h0000);
        pulse(5'h00, 1'b1);
        rchk(4'h4, 16'h0003, "no cascade");
        // PWM: period 0..7, duty taken only at period end
        wreg(4'h0, 16'h0000);
        wreg(4'h4, 16'h0000);
        wreg(4'h2, 16'h0003);
        wreg(4'h3, 16'h0007);
        wreg(4'h0, 16'h1C06);
        wait_for(0);
        duty(16'h0003, "duty");
        wreg(4'h2, 16'h0005);
        wait_for(0);
        duty(16'h0005, "new duty");
        wreg(4'h2, 16'h0000);
        wait_for(0);
        chk({15'h0, compare_out}, 16'h0000, "zero duty");
        results;
    end
endmodule // output_compare_timebase_tb

bind output_compare_timebase oc_port_checker oc_port_checker_inst (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wrap_out(wrap_out), .compare_out(compare_out),
    .compare_event(compare_event), .irq(irq));
